/* File: src/pmx_cfg.svh */
/*
  Offsets, field positions, reset values for the crossover/heartbeat
  control and status register.
  Assumes inclusion by bare name from pmx package users.
*/
`ifndef PMX_CFG_SVH
`define PMX_CFG_SVH

`define PMX_REG_INDEX      5'h1B
`define PMX_BIT_SRC        15
`define PMX_BIT_AUTO_EN    14
`define PMX_BIT_MAN_STATE  13
`define PMX_BIT_SQE_OFF    11
`define PMX_BIT_PLL_REF    10
`define PMX_BIT_POL_REV    4
`define PMX_CTRL_RESET     5'h00
`define PMX_SYNC_DEPTH     3

`endif

/* File: src/pmx_pkg.sv */
/*
  Types for the crossover/heartbeat control register block.
  Assumes pmx_cfg.svh holds the numeric constants.
*/
package pmx_pkg;
  typedef enum logic [2:0] {
    PMX_MODE_MANUAL_STRAIGHT = 3'h1,
    PMX_MODE_MANUAL_CROSS    = 3'h2,
    PMX_MODE_AUTO            = 3'h4
  } pmx_mode_t;
endpackage

/* File: src/pmx_sync.sv */
/*
  Three-flop synchroniser with agreement filter for one level input.
  Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
`default_nettype none
module pmx_sync (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  input  wire logic async_i,
  output logic      level_o
);
  typedef struct packed {
    logic [2:0] sh;
    logic       lvl;
  } pmx_sync_state_t;

  pmx_sync_state_t st_reg;
  pmx_sync_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sh = {st_reg.sh[1:0], async_i};
    // only stages two and three are compared; stage one feeds stage two alone
    if (st_reg.sh[1] == st_reg.sh[2]) begin
      st_next.lvl = st_reg.sh[2];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_o = st_reg.lvl;
endmodule
`default_nettype wire

/* File: src/pmx_ctrl_reg.sv */
/*
  Per-port crossover source/mode, heartbeat disable, rx PLL lock control
  and rx polarity status register, on the PHY management register port.
  Assumes a single-cycle management access port (index, write strobe,
  read strobe) on clock_i, straps latched elsewhere and held stable,
  and a port PHY reset pulse from the chip reset control logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmx_cfg.svh"

module pmx_ctrl_reg (
  input  wire logic              clock_i,
  input  wire logic              nrst_i,
  input  wire logic [4:0]        reg_index_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  input  wire logic [15:0]       reg_wdata_i,
  output logic      [15:0]       reg_rdata_o,
  output logic                   reg_rvalid_o,
  input  wire logic              port_phy_reset_i,
  input  wire logic              phy_reset_bit_i,
  input  wire logic              strap_manual_cross_i,
  input  wire logic              strap_auto_cross_i,
  input  wire logic              rx_polarity_reversed_i,
  output pmx_pkg::pmx_mode_t     crossover_mode_o,
  output logic                   heartbeat_test_enable_o,
  output logic                   rx_pll_force_reference_lock_o,
  output logic                   rx_10m_receive_enable_o
);
  import pmx_pkg::*;

  typedef struct packed {
    logic               crossover_control_source;
    logic               crossover_auto_enable;
    logic               crossover_manual_state;
    logic               heartbeat_test_disable;
    logic               rx_pll_force_reference_lock;
    logic               straps_taken;
    logic               strap_manual;
    logic               strap_auto;
    pmx_mode_t          mode;
    logic [15:0]        rdata;
    logic               rvalid;
  } pmx_state_t;

  pmx_state_t st_reg;
  pmx_state_t st_next;
  logic       pol_sync;
  logic       hit;
  logic [15:0] rd_word;
  logic       use_auto;
  logic       use_cross;

  pmx_sync u_pol_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i (rx_polarity_reversed_i),
    .level_o (pol_sync)
  );

  assign hit = (reg_index_i == `PMX_REG_INDEX);

  always_comb begin
    st_next   = st_reg;
    rd_word   = 16'h0000;
    use_auto  = 1'b0;
    use_cross = 1'b0;
    // straps are caught by a clocked step after reset release, not by the reset itself
    if (!st_reg.straps_taken) begin
      st_next.straps_taken = 1'b1;
      st_next.strap_manual = strap_manual_cross_i;
      st_next.strap_auto   = strap_auto_cross_i;
    end
    if (reg_write_i && hit) begin
      st_next.crossover_control_source    = reg_wdata_i[`PMX_BIT_SRC];
      st_next.crossover_auto_enable       = reg_wdata_i[`PMX_BIT_AUTO_EN];
      st_next.crossover_manual_state      = reg_wdata_i[`PMX_BIT_MAN_STATE];
      st_next.heartbeat_test_disable      = reg_wdata_i[`PMX_BIT_SQE_OFF];
      st_next.rx_pll_force_reference_lock = reg_wdata_i[`PMX_BIT_PLL_REF];
    end
    if (port_phy_reset_i && phy_reset_bit_i) begin
      {st_next.crossover_control_source, st_next.crossover_auto_enable,
       st_next.crossover_manual_state, st_next.heartbeat_test_disable,
       st_next.rx_pll_force_reference_lock} = `PMX_CTRL_RESET;
    end
    if (st_reg.crossover_control_source) begin
      use_auto  = st_reg.crossover_auto_enable;
      // reserved 11 falls back to automatic, the safer guess
      use_cross = st_reg.crossover_manual_state;
    end else begin
      use_auto  = st_reg.strap_auto;
      use_cross = st_reg.strap_manual;
    end
    if (use_auto) begin
      st_next.mode = PMX_MODE_AUTO;
    end else if (use_cross) begin
      st_next.mode = PMX_MODE_MANUAL_CROSS;
    end else begin
      st_next.mode = PMX_MODE_MANUAL_STRAIGHT;
    end
    rd_word[`PMX_BIT_SRC]       = st_reg.crossover_control_source;
    rd_word[`PMX_BIT_AUTO_EN]   = st_reg.crossover_auto_enable;
    rd_word[`PMX_BIT_MAN_STATE] = st_reg.crossover_manual_state;
    rd_word[`PMX_BIT_SQE_OFF]   = st_reg.heartbeat_test_disable;
    rd_word[`PMX_BIT_PLL_REF]   = st_reg.rx_pll_force_reference_lock;
    rd_word[`PMX_BIT_POL_REV]   = pol_sync;
    st_next.rvalid = reg_read_i;
    if (reg_read_i) begin
      st_next.rdata = hit ? rd_word : 16'h0000;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg <= '{mode: PMX_MODE_MANUAL_STRAIGHT, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o                   = st_reg.rdata;
  assign reg_rvalid_o                  = st_reg.rvalid;
  assign crossover_mode_o              = st_reg.mode;
  assign heartbeat_test_enable_o       = ~st_reg.heartbeat_test_disable;
  assign rx_pll_force_reference_lock_o = st_reg.rx_pll_force_reference_lock;
  assign rx_10m_receive_enable_o       = ~st_reg.rx_pll_force_reference_lock;

  property p_src_reg;
    @(posedge clock_i) disable iff (!nrst_i)
    st_reg.crossover_control_source && !st_reg.crossover_auto_enable
      && st_reg.crossover_manual_state |=> crossover_mode_o == PMX_MODE_MANUAL_CROSS;
  endproperty
  a_src_reg: assert property (p_src_reg) else $error("register cross mode wrong");

  property p_src_strap;
    @(posedge clock_i) disable iff (!nrst_i)
    !st_reg.crossover_control_source && st_reg.straps_taken && st_reg.strap_auto
      |=> crossover_mode_o == PMX_MODE_AUTO;
  endproperty
  a_src_strap: assert property (p_src_strap) else $error("strap auto mode wrong");

  property p_mode_auto;
    @(posedge clock_i) disable iff (!nrst_i)
    st_reg.crossover_control_source && st_reg.crossover_auto_enable
      && !st_reg.crossover_manual_state |=> crossover_mode_o == PMX_MODE_AUTO;
  endproperty
  a_mode_auto: assert property (p_mode_auto) else $error("auto mode not selected");

  property p_sqe;
    @(posedge clock_i) disable iff (!nrst_i)
    reg_write_i && hit && !(port_phy_reset_i && phy_reset_bit_i)
      |=> heartbeat_test_enable_o == !$past(reg_wdata_i[`PMX_BIT_SQE_OFF]);
  endproperty
  a_sqe: assert property (p_sqe) else $error("heartbeat enable wrong");

  property p_pll;
    @(posedge clock_i) disable iff (!nrst_i)
    reg_write_i && hit && !(port_phy_reset_i && phy_reset_bit_i)
      |=> rx_pll_force_reference_lock_o == $past(reg_wdata_i[`PMX_BIT_PLL_REF])
      && rx_10m_receive_enable_o == !$past(reg_wdata_i[`PMX_BIT_PLL_REF]);
  endproperty
  a_pll: assert property (p_pll) else $error("pll lock control wrong");

  property p_pol;
    @(posedge clock_i) disable iff (!nrst_i)
    reg_read_i && hit |=> reg_rvalid_o && reg_rdata_o[`PMX_BIT_POL_REV] == $past(pol_sync);
  endproperty
  a_pol: assert property (p_pol) else $error("polarity readback wrong");

  property p_phyrst;
    @(posedge clock_i) disable iff (!nrst_i)
    port_phy_reset_i && phy_reset_bit_i |=> !st_reg.crossover_control_source
      && !st_reg.crossover_auto_enable && !st_reg.crossover_manual_state
      && heartbeat_test_enable_o && !rx_pll_force_reference_lock_o;
  endproperty
  a_phyrst: assert property (p_phyrst) else $error("phy reset left bits set");

  property p_rsvd;
    @(posedge clock_i) disable iff (!nrst_i)
    reg_rvalid_o |-> (reg_rdata_o & 16'h13EF) == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  property p_other_idx;
    @(posedge clock_i) disable iff (!nrst_i)
    reg_read_i && !hit |=> reg_rvalid_o && reg_rdata_o == 16'h0000;
  endproperty
  a_other_idx: assert property (p_other_idx) else $error("other index read nonzero");

  property p_strap_cross;
    @(posedge clock_i) disable iff (!nrst_i)
    !st_reg.crossover_control_source && st_reg.straps_taken && !st_reg.strap_auto
      && st_reg.strap_manual |=> crossover_mode_o == PMX_MODE_MANUAL_CROSS;
  endproperty
  a_strap_cross: assert property (p_strap_cross) else $error("strap cross mode wrong");

  property p_mode_straight;
    @(posedge clock_i) disable iff (!nrst_i)
    st_reg.crossover_control_source && !st_reg.crossover_auto_enable
      && !st_reg.crossover_manual_state |=> crossover_mode_o == PMX_MODE_MANUAL_STRAIGHT;
  endproperty
  a_mode_straight: assert property (p_mode_straight) else $error("straight mode wrong");

  // unqualified pulse must leave the source, heartbeat disable and PLL lock bits alone
  property p_phyrst_qual;
    @(posedge clock_i) disable iff (!nrst_i)
    port_phy_reset_i && !phy_reset_bit_i && !reg_write_i
      |=> $stable(st_reg.crossover_control_source) && $stable(heartbeat_test_enable_o)
      && $stable(rx_pll_force_reference_lock_o);
  endproperty
  a_phyrst_qual: assert property (p_phyrst_qual) else $error("unqualified reset acted");
endmodule
`default_nettype wire

/* File: testbench/phy_mdix_sqe_control_reg_tb_top.sv */
/*
  Self-checking bench for the crossover/heartbeat control register.
  Assumes src/ on the include path and pmx_pkg compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_mdix_sqe_control_reg_tb_top;
  import pmx_pkg::*;
  logic        clock_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [4:0]  reg_index_i = 5'h00;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic        rst_pulse = 1'b0;
  logic        rst_bit = 1'b0;
  logic        s_man = 1'b0;
  logic        s_auto = 1'b0;
  logic        pol = 1'b0;
  logic [15:0] rdata;
  logic        rvalid;
  pmx_mode_t   mode;
  logic        hb;
  logic        pll;
  logic        rx10;
  int          errors = 0;
  int          samples_checked = 0;
  always #2.5 clock_i = ~clock_i;
  pmx_ctrl_reg dut (.clock_i(clock_i), .nrst_i(nrst_i), .reg_index_i(reg_index_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .port_phy_reset_i(rst_pulse),
    .phy_reset_bit_i(rst_bit), .strap_manual_cross_i(s_man), .strap_auto_cross_i(s_auto),
    .rx_polarity_reversed_i(pol), .crossover_mode_o(mode), .heartbeat_test_enable_o(hb),
    .rx_pll_force_reference_lock_o(pll), .rx_10m_receive_enable_o(rx10));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic man, input logic aut);
    @(negedge clock_i);
    nrst_i = 1'b0;
    s_man = man;
    s_auto = aut;
    repeat (10) @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clock_i);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] d);
    @(negedge clock_i);
    reg_index_i = idx;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    @(negedge clock_i);
    reg_write_i = 1'b0;
    @(negedge clock_i);
  endtask
  task automatic rd(input logic [4:0] idx, input logic [15:0] exp, input string what);
    @(negedge clock_i);
    reg_index_i = idx;
    reg_read_i = 1'b1;
    @(negedge clock_i);
    reg_read_i = 1'b0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid});
    chk(what, exp, rdata);
  endtask
  task automatic outs(input logic [2:0] exp);
    chk("hb_pll_rx10", {13'h0000, exp}, {13'h0000, hb, pll, rx10});
  endtask
  task automatic t_defaults();
    rd(5'h1B, 16'h0000, "reset word");
    outs(3'h5);
    chk("strap mode", 16'(PMX_MODE_MANUAL_STRAIGHT), 16'(mode));
  endtask
  task automatic t_modes();
    logic [15:0] w[3] = '{16'h8000, 16'hA000, 16'hC000};
    pmx_mode_t   m[3] = '{PMX_MODE_MANUAL_STRAIGHT, PMX_MODE_MANUAL_CROSS, PMX_MODE_AUTO};
    for (int i = 0; i < 3; i++) begin
      wr(5'h1B, w[i]);
      chk("reg mode", 16'(m[i]), 16'(mode));
      rd(5'h1B, w[i], "mode word");
    end
  endtask
  task automatic t_sqe_pll();
    wr(5'h1B, 16'h0C00);
    outs(3'h2);
    wr(5'h1B, 16'h0800);
    outs(3'h1);
  endtask
  task automatic t_reserved();
    wr(5'h1B, 16'hDFFF); // enable and state never both set
    rd(5'h1B, 16'hCC00, "reserved bits");
    wr(5'h1A, 16'h0000);
    rd(5'h1B, 16'hCC00, "other index write");
    rd(5'h1A, 16'h0000, "other index read");
  endtask
  task automatic t_phy_reset();
    @(negedge clock_i);
    rst_pulse = 1'b1;
    @(negedge clock_i);
    rst_pulse = 1'b0;
    rd(5'h1B, 16'hCC00, "unqualified phy reset");
    rst_bit = 1'b1;
    rst_pulse = 1'b1;
    reg_index_i = 5'h1B;
    reg_wdata_i = 16'h8C00;
    reg_write_i = 1'b1;
    @(negedge clock_i);
    rst_pulse = 1'b0;
    rst_bit = 1'b0;
    reg_write_i = 1'b0;
    rd(5'h1B, 16'h0000, "phy reset over write");
    outs(3'h5);
  endtask
  task automatic t_polarity();
    pol = 1'b1;
    repeat (8) @(negedge clock_i);
    rd(5'h1B, 16'h0010, "polarity reversed");
    wr(5'h1B, 16'h0010);
    pol = 1'b0;
    repeat (8) @(negedge clock_i);
    rd(5'h1B, 16'h0000, "polarity normal");
  endtask
  task automatic t_straps();
    do_reset(1'b1, 1'b0);
    chk("strap cross", 16'(PMX_MODE_MANUAL_CROSS), 16'(mode));
    do_reset(1'b1, 1'b1);
    chk("strap both", 16'(PMX_MODE_AUTO), 16'(mode));
    do_reset(1'b0, 1'b1);
    chk("strap auto", 16'(PMX_MODE_AUTO), 16'(mode));
    wr(5'h1B, 16'h8000);
    chk("straps ignored", 16'(PMX_MODE_MANUAL_STRAIGHT), 16'(mode));
  endtask
  task automatic end_of_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // generous bound; the sequence needs well under 1000 cycles
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
  initial begin
    do_reset(1'b0, 1'b0);
    t_defaults();
    t_modes();
    t_sqe_pll();
    t_reserved();
    t_phy_reset();
    t_polarity();
    t_straps();
    end_of_test();
  end
endmodule
`default_nettype wire
